// *** src/sewac_device.sv ***
`timescale 1ns/1ps
`include "sewac_defs.svh"
module sewac_device
	import sewac_pkg::*;
#(
	parameter int unsigned WRITE_CYCLES = `SEWAC_TWC_CYC
) (
	input  wire logic       clk,
	input  wire logic       resetn,
	sewac_if.dev            bus,
	input  wire logic [2:0] client_addr,
	input  wire logic       write_protect,
	output logic            busy,
	output logic            standby
);

	sewac_dst_e  st;
	logic [5:0]  pin_meta;
	logic [5:0]  pin_sync;
	logic        scl_d;
	logic        sda_d;
	logic        scl_s;
	logic        sda_s;
	logic        wp_s;
	logic [2:0]  ca_s;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_c;
	logic        stop_c;
	logic [3:0]  cnt;
	logic        in_ack;
	logic [7:0]  sh;
	logic [7:0]  tx;
	logic [15:0] addr;
	logic [7:0]  pbuf [`SEWAC_PAGE_BYTES];
	logic [`SEWAC_PAGE_BYTES-1:0] pmask;
	logic        wr_pend;
	logic        sda_drv;
	logic        prog_go;
	logic [31:0] twc;
	logic [5:0]  widx;
	logic [`SEWAC_CODE_LEN-1:0] mem [`SEWAC_MEM_WORDS];
	logic [31:0] rd_fix;
	logic [7:0]  rd_byte;
	logic [15:0] wr_baddr;
	logic [31:0] old_fix;
	logic [31:0] mrg;
	logic        mrg_any;

	////////////////////////////////////////////////////////////////////////////////
	// Check bits are the XOR of the code positions of set data bits
	function automatic logic [5:0] ecc_par(input logic [31:0] d);
		logic [5:0] p;
		int         j;
		p = '0;
		j = 0;
		for (int pos = 1; pos <= `SEWAC_CODE_LEN; pos++) begin
			if ((pos & (pos - 1)) != 0) begin
				if (d[j]) p = p ^ 6'(pos);
				j++;
			end
		end
		return p;
	endfunction : ecc_par

	// Flip the single data bit that the syndrome points at
	function automatic logic [31:0] ecc_fix(input logic [`SEWAC_CODE_LEN-1:0] w);
		logic [5:0]  syn;
		logic [31:0] d;
		int          j;
		d = w[31:0];
		syn = w[37:32] ^ ecc_par(w[31:0]);
		j = 0;
		for (int pos = 1; pos <= `SEWAC_CODE_LEN; pos++) begin
			if ((pos & (pos - 1)) != 0) begin
				if (6'(pos) == syn) d[j] = ~d[j];
				j++;
			end
		end
		return d;
	endfunction : ecc_fix

	////////////////////////////////////////////////////////////////////////////////
	// Pins come from another domain: two flops before any logic looks at them
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pin_meta <= 6'h03;
			pin_sync <= 6'h03;
		end else begin
			pin_meta <= {client_addr, write_protect, bus.sda, bus.scl};
			pin_sync <= pin_meta;
		end
	end

	assign scl_s = pin_sync[0];
	assign sda_s = pin_sync[1];
	assign wp_s  = pin_sync[2];
	assign ca_s  = pin_sync[5:3];

	// Previous line levels for edge detection
	always_ff @(posedge clk) begin
		if (!resetn) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_c  = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_c   = scl_s & scl_d & ~sda_d & sda_s;

	////////////////////////////////////////////////////////////////////////////////
	// Read path: any single flipped data bit is repaired before shifting out
	assign rd_fix  = ecc_fix(mem[addr[`SEWAC_MEM_AW+1:2]]);
	assign rd_byte = rd_fix[{addr[1:0], 3'h0} +: 8];

	////////////////////////////////////////////////////////////////////////////////
	// Serial protocol; SDA only changes after a seen SCL fall, so never while high
	always_ff @(posedge clk) begin
		prog_go <= 1'b0;
		if (!resetn) begin
			st      <= DST_IDLE;
			cnt     <= '0;
			in_ack  <= 1'b0;
			sh      <= '0;
			tx      <= '0;
			addr    <= '0;
			pmask   <= '0;
			wr_pend <= 1'b0;
			sda_drv <= 1'b0;
		end else if (start_c) begin
			// A start always restarts the interface; programming runs on
			st      <= DST_DEVADR;
			cnt     <= '0;
			in_ack  <= 1'b0;
			sda_drv <= 1'b0;
			wr_pend <= 1'b0;
		end else if (stop_c) begin
			// Protected target: nothing stored and no busy period
			if (st == DST_WDATA && wr_pend && !wp_s) begin
				prog_go <= 1'b1;
			end
			st      <= DST_IDLE;
			cnt     <= '0;
			in_ack  <= 1'b0;
			sda_drv <= 1'b0;
			wr_pend <= 1'b0;
		end else if (scl_rise) begin
			if (!in_ack && cnt != `SEWAC_ACK_BIT) begin
				sh  <= {sh[6:0], sda_s};
				cnt <= cnt + 4'h1;
			end else if (in_ack && st == DST_RDATA && sda_s) begin
				st <= DST_IDLE;
			end
		end else if (scl_fall) begin
			if (in_ack) begin
				// End of the ninth clock: release, or put out next read bit
				in_ack  <= 1'b0;
				cnt     <= '0;
				sda_drv <= 1'b0;
				if (st == DST_RDATA) begin
					sda_drv <= ~rd_byte[7];
					tx      <= {rd_byte[6:0], 1'b0};
					addr    <= addr + 16'h0001;
				end
			end else if (cnt == `SEWAC_ACK_BIT) begin
				// Ack is driven from this fall through the whole next high phase
				in_ack  <= 1'b1;
				sda_drv <= 1'b0;
				case (st)
					DST_DEVADR: begin
						if (sh[7:4] == `SEWAC_DEV_TYPE && sh[3:1] == ca_s && !busy) begin
							sda_drv <= 1'b1;
							st      <= sh[0] ? DST_RDATA : DST_ADRH;
						end else begin
							st <= DST_IGNORE;
						end
					end
					DST_ADRH: begin
						sda_drv     <= 1'b1;
						addr[15:8]  <= sh;
						st          <= DST_ADRL;
					end
					DST_ADRL: begin
						sda_drv    <= 1'b1;
						addr[7:0]  <= sh;
						pmask      <= '0;
						st         <= DST_WDATA;
					end
					DST_WDATA: begin
						// Only the low seven bits move, so excess bytes overwrite
						sda_drv           <= 1'b1;
						pbuf[addr[6:0]]   <= sh;
						pmask[addr[6:0]]  <= 1'b1;
						wr_pend           <= 1'b1;
						addr[6:0]         <= addr[6:0] + 7'h01;
					end
					default: begin
					end
				endcase
			end else if (st == DST_RDATA) begin
				sda_drv <= ~tx[7];
				tx      <= {tx[6:0], 1'b0};
			end
		end
	end

	assign bus.dev_sda_o  = 1'b0;
	assign bus.dev_sda_oe = sda_drv;

	////////////////////////////////////////////////////////////////////////////////
	// Self-timed cycle: busy for exactly WRITE_CYCLES clocks, untouched by bus resets
	always_ff @(posedge clk) begin
		if (!resetn) begin
			busy <= 1'b0;
			twc  <= '0;
			widx <= '0;
		end else if (prog_go) begin
			busy <= 1'b1;
			twc  <= '0;
			widx <= '0;
		end else if (busy) begin
			twc <= twc + 32'h1;
			if (twc == WRITE_CYCLES - 1) begin
				busy <= 1'b0;
			end
			if (widx != 6'(`SEWAC_PAGE_WORDS)) begin
				widx <= widx + 6'h01;
			end
		end
	end

	// Merge loaded bytes into the old word; untouched bytes keep corrected values
	assign wr_baddr = {addr[15:7], widx[4:0], 2'h0};
	assign old_fix  = ecc_fix(mem[wr_baddr[`SEWAC_MEM_AW+1:2]]);

	always_comb begin
		mrg     = old_fix;
		mrg_any = 1'b0;
		for (int k = 0; k < 4; k++) begin
			if (pmask[{widx[4:0], 2'(k)}]) begin
				mrg[8*k +: 8] = pbuf[{widx[4:0], 2'(k)}];
				mrg_any       = 1'b1;
			end
		end
	end

	// One physical word per clock; the whole word is rewritten with fresh check bits
	always_ff @(posedge clk) begin
		if (!resetn) begin
			for (int i = 0; i < `SEWAC_MEM_WORDS; i++) begin
				mem[i] <= '0;
			end
		end else if (busy && widx != 6'(`SEWAC_PAGE_WORDS) && mrg_any) begin
			mem[wr_baddr[`SEWAC_MEM_AW+1:2]] <= {ecc_par(mrg), mrg};
		end
	end

	// Low-power indication: idle or unaddressed, and no programming
	always_ff @(posedge clk) begin
		if (!resetn) begin
			standby <= 1'b1;
		end else begin
			// Trigger pulse counts as busy so standby never overlaps the first busy cycle
			standby <= !busy && !prog_go && (st == DST_IDLE || st == DST_IGNORE);
		end
	end

endmodule : sewac_device

// *** src/sewac_defs.svh ***
`ifndef SEWAC_DEFS_SVH
`define SEWAC_DEFS_SVH

// System clock and bus clock rates
`define SEWAC_CLK_KHZ    25000
`define SEWAC_SCL_KHZ    1000
// Half-step of the host bit timing, rounded up so SCL never exceeds the limit
`define SEWAC_SCL_HALF   ((`SEWAC_CLK_KHZ + 2 * `SEWAC_SCL_KHZ - 1) / (2 * `SEWAC_SCL_KHZ))
`define SEWAC_HALF_W     4

// Self-timed programming time
`define SEWAC_TWC_US     5000
`define SEWAC_TWC_CYC    (`SEWAC_TWC_US * (`SEWAC_CLK_KHZ / 1000))

// Addressing
`define SEWAC_DEV_TYPE   4'hA
`define SEWAC_PAGE_BYTES 128
`define SEWAC_PAGE_WORDS 32
`define SEWAC_ACK_BIT    4'h8
`define SEWAC_RST_CLOCKS 4'h9

// Stored words: index width of the implemented array, code length
`define SEWAC_MEM_AW     6
`define SEWAC_MEM_WORDS  64
`define SEWAC_CODE_LEN   38

`endif

// *** src/sewac_pkg.sv ***
package sewac_pkg;

	// Device-side protocol states
	typedef enum logic [2:0] {
		DST_IDLE,
		DST_DEVADR,
		DST_ADRH,
		DST_ADRL,
		DST_WDATA,
		DST_RDATA,
		DST_IGNORE
	} sewac_dst_e;

	// Host command opcodes
	typedef enum logic [2:0] {
		HOP_START,
		HOP_STOP,
		HOP_WRITE,
		HOP_READ,
		HOP_RECOVER
	} sewac_hop_e;

	// Host sequencer states
	typedef enum logic [2:0] {
		HST_IDLE,
		HST_START,
		HST_STOP,
		HST_BITS,
		HST_RECOV
	} sewac_hst_e;

endpackage : sewac_pkg

// *** src/sewac_if.sv ***
`timescale 1ns/1ps
interface sewac_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;

	// Open-drain wires with pull-up: low while any enabled driver outputs low
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

	modport dev (
		input  scl,
		input  sda,
		output dev_sda_o,
		output dev_sda_oe
	);

	modport host (
		input  scl,
		input  sda,
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe
	);
endinterface : sewac_if

// *** src/sewac_host.sv ***
`timescale 1ns/1ps
`include "sewac_defs.svh"
module sewac_host
	import sewac_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	sewac_if.host           bus,
	input  wire logic       cmd_valid,
	output logic            cmd_ready,
	input  sewac_hop_e      cmd_op,
	input  wire logic [7:0] cmd_data,
	input  wire logic       cmd_nack,
	output logic            rsp_valid,
	output logic [7:0]      rsp_data,
	output logic            rsp_ack
);

	sewac_hst_e               hs;
	logic [`SEWAC_HALF_W-1:0] hcnt;
	logic                     tick;
	logic [1:0]               step;
	logic [3:0]               bitn;
	logic [7:0]               sh;
	logic                     rd;
	logic                     nack;
	logic                     scl_drv;
	logic                     sda_drv;
	logic                     sda_m;
	logic                     sda_s;

	////////////////////////////////////////////////////////////////////////////////
	// Step divider; three steps per bit keep SCL well under 1 MHz for polling
	always_ff @(posedge clk) begin
		if (!resetn || tick) begin
			hcnt <= '0;
		end else begin
			hcnt <= hcnt + 1'b1;
		end
	end

	assign tick = (hcnt == `SEWAC_HALF_W'(`SEWAC_SCL_HALF - 1));

	// SDA from the bus is resynchronised before sampling
	always_ff @(posedge clk) begin
		if (!resetn) begin
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			sda_m <= bus.sda;
			sda_s <= sda_m;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Command sequencer; SDA moves only with SCL held low except in start/stop
	always_ff @(posedge clk) begin
		rsp_valid <= 1'b0;
		if (!resetn) begin
			hs        <= HST_IDLE;
			cmd_ready <= 1'b1;
			step      <= '0;
			bitn      <= '0;
			sh        <= '0;
			rd        <= 1'b0;
			nack      <= 1'b0;
			scl_drv   <= 1'b0;
			sda_drv   <= 1'b0;
			rsp_data  <= '0;
			rsp_ack   <= 1'b0;
		end else begin
			case (hs)
				HST_IDLE: begin
					if (cmd_valid && cmd_ready) begin
						cmd_ready <= 1'b0;
						step      <= '0;
						bitn      <= '0;
						sh        <= cmd_data;
						rd        <= (cmd_op == HOP_READ);
						nack      <= cmd_nack;
						case (cmd_op)
							HOP_START:   hs <= HST_START;
							HOP_STOP:    hs <= HST_STOP;
							HOP_RECOVER: hs <= HST_RECOV;
							default:     hs <= HST_BITS;
						endcase
					end
				end
				HST_START: if (tick) begin
					step <= step + 2'h1;
					if (step == 2'h0) sda_drv <= 1'b0;
					if (step == 2'h1) scl_drv <= 1'b0;
					if (step == 2'h2) sda_drv <= 1'b1;
					if (step == 2'h3) begin
						scl_drv   <= 1'b1;
						hs        <= HST_IDLE;
						cmd_ready <= 1'b1;
						rsp_valid <= 1'b1;
					end
				end
				HST_STOP: if (tick) begin
					step <= step + 2'h1;
					if (step == 2'h0) sda_drv <= 1'b1;
					if (step == 2'h1) scl_drv <= 1'b0;
					if (step == 2'h2) begin
						sda_drv   <= 1'b0;
						hs        <= HST_IDLE;
						cmd_ready <= 1'b1;
						rsp_valid <= 1'b1;
					end
				end
				HST_BITS: if (tick) begin
					step <= (step == 2'h2) ? 2'h0 : step + 2'h1;
					if (step == 2'h0) begin
						// Ninth bit: write releases for the device, read acks or not
						sda_drv <= (bitn == `SEWAC_ACK_BIT) ? (rd & ~nack) : (~rd & ~sh[7]);
					end
					if (step == 2'h1) scl_drv <= 1'b0;
					if (step == 2'h2) begin
						scl_drv <= 1'b1;
						bitn    <= bitn + 4'h1;
						if (bitn != `SEWAC_ACK_BIT) begin
							sh <= {sh[6:0], sda_s};
						end else begin
							rsp_ack   <= ~sda_s;
							rsp_data  <= sh;
							hs        <= HST_IDLE;
							cmd_ready <= 1'b1;
							rsp_valid <= 1'b1;
						end
					end
				end
				HST_RECOV: if (tick) begin
					step <= (step == 2'h2) ? 2'h0 : step + 2'h1;
					if (step == 2'h0) begin
						sda_drv <= 1'b0;
						if (sda_s || bitn == `SEWAC_RST_CLOCKS) begin
							rsp_ack   <= sda_s;
							hs        <= HST_IDLE;
							cmd_ready <= 1'b1;
							rsp_valid <= 1'b1;
						end
					end
					if (step == 2'h1) scl_drv <= 1'b0;
					if (step == 2'h2) begin
						scl_drv <= 1'b1;
						bitn    <= bitn + 4'h1;
					end
				end
				default: hs <= HST_IDLE;
			endcase
		end
	end

	assign bus.host_scl_o  = 1'b0;
	assign bus.host_scl_oe = scl_drv;
	assign bus.host_sda_o  = 1'b0;
	assign bus.host_sda_oe = sda_drv;

endmodule : sewac_host

// *** tb/sewac_monitor.sv ***
`timescale 1ns/1ps
module sewac_monitor #(
	parameter int unsigned WRITE_CYCLES = 64
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_oe,
	input wire logic busy,
	input wire logic standby
);
	logic [31:0] busy_cnt;
	logic [7:0]  stop_age;
	logic        scl_q;
	logic        sda_q;

	////////////////////////////////////////////////////////////////////////////////
	// Length of the current busy run, zero while idle
	always_ff @(posedge clk) begin
		busy_cnt <= busy ? busy_cnt + 32'h1 : 32'h0;
	end

	// Wire levels one cycle back, for stop detection
	always_ff @(posedge clk) begin
		scl_q <= scl;
		sda_q <= sda;
	end

	// Cycles since the last stop; saturates so an old stop never looks recent
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stop_age <= 8'hFF;
		end else if (scl && scl_q && sda && !sda_q) begin
			stop_age <= 8'h00;
		end else if (stop_age != 8'hFF) begin
			stop_age <= stop_age + 8'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	AST_NO_ACK_BUSY: assert property (busy |-> !dev_sda_oe)
		else $error("device drove SDA while programming");
	AST_BUSY_LEN: assert property ($fell(busy) |-> busy_cnt == WRITE_CYCLES)
		else $error("busy length differs from programming count");
	AST_ACK_HOLD: assert property (($rose(scl) && dev_sda_oe) |-> (dev_sda_oe && !sda)[*8])
		else $error("device SDA low not held over clock high");
	AST_SDA_SCL_LOW: assert property ($changed(dev_sda_oe) |-> !scl)
		else $error("device changed SDA while SCL high");
	AST_PROG_AFTER_STOP: assert property ($rose(busy) |-> stop_age inside {[8'h01:8'h0C]})
		else $error("programming began without a recent stop");
	AST_STANDBY_QUIET: assert property (standby |-> !busy && !dev_sda_oe)
		else $error("standby while busy or driving SDA");
	AST_ACK_CLOCKED: assert property ($rose(dev_sda_oe) |-> ##[1:40] scl)
		else $error("device drive not followed by a clock pulse");
	AST_STANDBY_IDLE: assert property ((standby && scl && sda) ##1 (scl && sda) |-> standby)
		else $error("standby lost on an idle bus");
endmodule : sewac_monitor

// *** tb/serial_eeprom_write_ack_control_tb.sv ***
`timescale 1ns/1ps
module serial_eeprom_write_ack_control_tb
	import sewac_pkg::*;
;
	localparam int unsigned WC = 1000;
	logic       clk, resetn, write_protect, busy, standby;
	logic [2:0] client_addr, ca;
	logic       cmd_valid, cmd_ready, cmd_nack, rsp_valid, rsp_ack, r_ack;
	sewac_hop_e cmd_op;
	logic [7:0] cmd_data, rsp_data, r_data;
	logic [7:0] mem [256];
	int         error_cnt, checked;

	sewac_if bus_if();
	sewac_device #(.WRITE_CYCLES(WC)) sewac_device_i (.clk(clk), .resetn(resetn), .bus(bus_if),
		.client_addr(client_addr), .write_protect(write_protect), .busy(busy), .standby(standby));
	sewac_host sewac_host_i (.clk(clk), .resetn(resetn), .bus(bus_if), .cmd_valid(cmd_valid),
		.cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data), .cmd_nack(cmd_nack),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_ack(rsp_ack));
	sewac_monitor #(.WRITE_CYCLES(WC)) sewac_monitor_i (.clk(clk), .resetn(resetn),
		.scl(bus_if.scl), .sda(bus_if.sda), .dev_sda_oe(bus_if.dev_sda_oe), .busy(busy),
		.standby(standby));

	////////////////////////////////////////////////////////////////////////////////
	task chk_bit(input string w, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %b seen %b", w, e, g);
		end
	endtask : chk_bit

	task chk_byte(input string w, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", w, e, g);
		end
	endtask : chk_byte

	task test_done;
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done

	// One host command: ready is high after the last response, so one offered cycle is taken
	task op(input sewac_hop_e o, input logic [7:0] d, input logic nk);
		int n;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_op <= o;
		cmd_data <= d;
		cmd_nack <= nk;
		@(posedge clk);
		cmd_valid <= 1'b0;
		n = 0;
		// Response pulse is looked at mid-cycle, where it has settled
		do begin
			@(negedge clk);
			n++;
		end while (rsp_valid !== 1'b1 && n < 600);
		chk_bit("response", 1'b1, rsp_valid);
		r_ack = rsp_ack;
		r_data = rsp_data;
	endtask : op

	task wb(input logic [7:0] d, input logic e, input string w);
		op(HOP_WRITE, d, 1'b0);
		chk_bit(w, e, r_ack);
	endtask : wb

	task addr_phase(input logic [15:0] a);
		op(HOP_START, 8'h00, 1'b0);
		wb({4'hA, ca, 1'b0}, 1'b1, "dev ack");
		wb(a[15:8], 1'b1, "adrh ack");
		wb(a[7:0], 1'b1, "adrl ack");
	endtask : addr_phase

	// Page write; the model keeps bit 7 and wraps the low seven
	task page_wr(input logic [15:0] a, input int n, input logic wp);
		int i;
		logic [7:0] d;
		write_protect <= wp;
		addr_phase(a);
		for (i = 0; i < n; i++) begin
			d = 8'($urandom);
			wb(d, 1'b1, "data ack");
			if (!wp) mem[{a[7], 7'(a[6:0] + i)}] = d;
		end
		op(HOP_STOP, 8'h00, 1'b0);
		// Stop is seen through the pin synchronisers, so busy follows a few clocks later
		repeat (8) @(negedge clk);
		chk_bit("busy after stop", !wp, busy);
	endtask : page_wr

	task poll_done;
		int k;
		op(HOP_START, 8'h00, 1'b0);
		wb({4'hA, ca, 1'b0}, 1'b0, "busy poll");
		for (k = 0; k < 20 && r_ack !== 1'b1; k++) begin
			op(HOP_START, 8'h00, 1'b0);
			op(HOP_WRITE, {4'hA, ca, 1'b0}, 1'b0);
		end
		chk_bit("poll ack", 1'b1, r_ack);
		chk_bit("busy done", 1'b0, busy);
		op(HOP_STOP, 8'h00, 1'b0);
	endtask : poll_done

	task rd(input logic [15:0] a, input int n);
		int i;
		addr_phase(a);
		op(HOP_START, 8'h00, 1'b0);
		wb({4'hA, ca, 1'b1}, 1'b1, "rd dev ack");
		for (i = 0; i < n; i++) begin
			op(HOP_READ, 8'h00, i == n - 1);
			chk_byte("read data", mem[8'(a[7:0] + i)], r_data);
		end
		op(HOP_STOP, 8'h00, 1'b0);
		repeat (8) @(negedge clk);
		chk_bit("standby", 1'b1, standby);
	endtask : rd

	////////////////////////////////////////////////////////////////////////////////
	// Free-running system clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Watchdog sized above the longest expected run
	initial begin
		#(40 * 100000);
		error_cnt++;
		test_done();
	end

	// Main sequence
	initial begin
		resetn = 1'b0;
		cmd_valid = 1'b0;
		cmd_op = HOP_START;
		cmd_data = 8'h00;
		cmd_nack = 1'b0;
		write_protect = 1'b0;
		error_cnt = 0;
		checked = 0;
		foreach (mem[i]) mem[i] = 8'h00;
		void'($urandom(32'h7a2f000d));
		ca = 3'($urandom);
		client_addr = ca;
		repeat (6) @(posedge clk);
		resetn <= 1'b1;
		repeat (4) @(posedge clk);
		chk_bit("standby reset", 1'b1, standby);
		page_wr(16'h0085, 1, 1'b0);
		poll_done();
		rd(16'h0084, 4);
		page_wr(16'h0105, 128, 1'b0);
		poll_done();
		rd(16'h0003, 3);
		rd(16'h007E, 4);
		page_wr(16'h0040, 4, 1'b1);
		rd(16'h0040, 2);
		op(HOP_START, 8'h00, 1'b0);
		wb({4'hA, ~ca, 1'b0}, 1'b0, "mismatch");
		op(HOP_STOP, 8'h00, 1'b0);
		chk_bit("standby mismatch", 1'b1, standby);
		// Abort a read while the device holds SDA, then recover the interface
		addr_phase(16'h0000);
		op(HOP_START, 8'h00, 1'b0);
		wb({4'hA, ca, 1'b1}, 1'b1, "rd dev ack");
		op(HOP_READ, 8'h00, 1'b0);
		op(HOP_RECOVER, 8'h00, 1'b0);
		chk_bit("recover", 1'b1, r_ack);
		op(HOP_STOP, 8'h00, 1'b0);
		page_wr(16'h0020, 2, 1'b0);
		op(HOP_RECOVER, 8'h00, 1'b0);
		chk_bit("busy kept", 1'b1, busy);
		poll_done();
		rd(16'h0020, 2);
		test_done();
	end
endmodule : serial_eeprom_write_ack_control_tb
